/* File: core/ric_top.sv */
`timescale 1ns/1ps
module ric_top #(
  parameter int num_irq = ric_pkg::num_sys_irq
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic reset_pin_in,
  output logic reset_pin_out,
  output logic reset_pin_oe,
  input wire logic power_up,
  input wire logic osc_fault,
  input wire logic wd_bad_key,
  input wire logic wd_timeout,
  input wire logic mode_control_pin,
  input wire logic [2:0] ext_irq_in,
  input wire logic [num_irq-1:0] periph_irq,
  input wire logic [num_irq-1:0] periph_level1,
  input wire logic [7:0] cpu_status_reg,
  input wire logic insn_done,
  input wire ric_pkg::ric_bus_type bus,
  output logic [7:0] rdata,
  output logic mode_latched,
  output logic cpu_reset,
  output logic clear_reg_ab,
  output ric_pkg::ric_cpu_init_type cpu_init,
  output logic vec_read,
  output logic [15:0] vec_addr,
  input wire logic [7:0] vec_data,
  output logic opcode_fetch,
  output logic irq_take,
  output logic [3:0] irq_index
);
  logic rst_s1;
  logic rst_n;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  logic [3:0] sync_in;
  logic [3:0] sync_out;
  logic pin_low;
  logic [2:0] xi_s;
  assign sync_in = {ext_irq_in, reset_pin_in};
  ric_sync #(.width(4)) u_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .din(sync_in),
    .dout(sync_out)
  );
  assign pin_low = ~sync_out[0];
  assign xi_s = sync_out[3:1];

  typedef enum logic [2:0] {
    ric_run, ric_hold, ric_wait, ric_vlo, ric_vhi, ric_fetch
  } ric_state_type;
  ric_state_type state;
  logic [4:0] cnt;
  logic [3:0] drive_cnt;
  logic internal_src;
  logic any_src;
  logic we;
  assign internal_src = wd_bad_key | wd_timeout | osc_fault | power_up;
  assign any_src = internal_src | pin_low;

  // Pin readback ignored while driving and for the two synchroniser cycles after
  // Otherwise the echo of our own drive would restart it forever
  logic [1:0] oe_hist;
  logic ext_low;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      oe_hist <= '1;
    end else begin
      oe_hist <= {oe_hist[0], reset_pin_oe};
    end
  end
  assign ext_low = pin_low & ~reset_pin_oe & ~(|oe_hist);

  // Pin drive counter; restarts while an internal cause stays active, or when the pin reads low outside the masked window
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      drive_cnt <= 4'(ric_pkg::pin_low_cycles);
    end else if (internal_src || ext_low) begin
      drive_cnt <= 4'(ric_pkg::pin_low_cycles);
    end else if (drive_cnt != 4'h0) begin
      drive_cnt <= drive_cnt - 4'h1;
    end
  end
  assign reset_pin_oe = (drive_cnt != 4'h0) | internal_src;
  assign reset_pin_out = 1'b0;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ric_hold;
      cnt <= 5'h00;
    end else if (internal_src || pin_low || reset_pin_oe) begin
      state <= ric_hold;
      cnt <= 5'h00;
    end else begin
      unique case (state)
        ric_run: begin
          state <= ric_run;
        end
        ric_hold: begin
          state <= ric_wait;
          cnt <= 5'h01;
        end
        ric_wait: begin
          cnt <= cnt + 5'h01;
          if (cnt == 5'(ric_pkg::start_cycles - 3)) begin
            state <= ric_vlo;
          end
        end
        ric_vlo: begin
          cnt <= cnt + 5'h01;
          state <= ric_vhi;
        end
        ric_vhi: begin
          cnt <= cnt + 5'h01;
          state <= ric_fetch;
        end
        ric_fetch: begin
          state <= ric_run;
        end
      endcase
    end
  end
  assign cpu_reset = (state != ric_run) && (state != ric_fetch);
  assign clear_reg_ab = (state == ric_hold);
  assign vec_read = (state == ric_vlo) || (state == ric_vhi);
  assign vec_addr = (state == ric_vhi) ? ric_pkg::vector_high_addr : ric_pkg::vector_low_addr;
  assign opcode_fetch = (state == ric_fetch);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_init <= {ric_pkg::status_reset, ric_pkg::stack_reset, 8'h00, 8'h00};
    end else if (state == ric_hold) begin
      cpu_init.cpu_status_reg <= ric_pkg::status_reset;
      cpu_init.stack_pointer <= ric_pkg::stack_reset;
    end else if (state == ric_vlo) begin
      cpu_init.pc_low_byte <= vec_data;
    end else if (state == ric_vhi) begin
      cpu_init.pc_high_byte <= vec_data;
    end
  end

  // Mode level sampled every ric_hold cycle; last value before leaving ric_hold stays
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_latched <= 1'b0;
    end else if (state == ric_hold) begin
      mode_latched <= mode_control_pin;
    end
  end

  // Source flags have no asynchronous reset so that they survive reset
  logic flag_power_up;
  logic flag_osc;
  logic flag_wd;
  assign we = bus.wr;
  always_ff @(posedge sys_clk) begin
    if (power_up) begin
      flag_power_up <= 1'b1;
    end else if (we && bus.addr == ric_pkg::system_config_0_addr && !bus.wdata[ric_pkg::power_up_bit]) begin
      flag_power_up <= 1'b0;
    end
    if (osc_fault) begin
      flag_osc <= 1'b1;
    end else if (we && bus.addr == ric_pkg::system_config_0_addr && !bus.wdata[ric_pkg::osc_fault_bit]) begin
      flag_osc <= 1'b0;
    end
    if (wd_bad_key || wd_timeout) begin
      flag_wd <= 1'b1;
    end else if (we && bus.addr == ric_pkg::timer1_control_2_addr && !bus.wdata[ric_pkg::wd_timeout_bit]) begin
      flag_wd <= 1'b0;
    end
  end

  // External interrupt control, one register each
  logic [7:0] xi_ctrl [3];
  logic [2:0] xi_prev;
  logic [2:0] xi_edge;
  logic [7:0] sc2;
  logic soft_rst_n;
  assign soft_rst_n = ~cpu_reset;
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_xi
      logic [15:0] my_addr;
      assign my_addr = ric_pkg::ext_irq_1_ctrl_addr + 16'(g);
      assign xi_edge[g] = xi_ctrl[g][ric_pkg::xi_polarity_bit] ? (xi_s[g] & ~xi_prev[g])
                          : (~xi_s[g] & xi_prev[g]);
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          xi_ctrl[g] <= ric_pkg::xi_ctrl_reset;
          xi_prev[g] <= 1'b1;
        end else if (!soft_rst_n) begin
          xi_ctrl[g] <= ric_pkg::xi_ctrl_reset;
          xi_prev[g] <= xi_s[g];
        end else begin
          xi_prev[g] <= xi_s[g];
          if (we && bus.addr == my_addr) begin
            xi_ctrl[g][6:0] <= bus.wdata[6:0];
          end
          // Set wins over a software clear in the same cycle
          if (xi_edge[g]) begin
            xi_ctrl[g][ric_pkg::xi_flag_bit] <= 1'b1;
          end else if (we && bus.addr == my_addr) begin
            xi_ctrl[g][ric_pkg::xi_flag_bit] <= bus.wdata[ric_pkg::xi_flag_bit];
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sc2 <= ric_pkg::sc2_reset;
    end else if (!soft_rst_n) begin
      sc2 <= ric_pkg::sc2_reset;
    end else if (we && bus.addr == ric_pkg::system_config_2_addr) begin
      if (!sc2[ric_pkg::privilege_disable_bit]) begin
        sc2 <= bus.wdata;
      end else begin
        sc2[7:2] <= bus.wdata[7:2];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else if (bus.rd) begin
      unique case (bus.addr)
        ric_pkg::system_config_0_addr:
          rdata <= {flag_power_up, 2'b00, flag_osc, 4'h0};
        ric_pkg::timer1_control_2_addr:
          rdata <= {2'b00, flag_wd, 5'h00};
        ric_pkg::ext_irq_1_ctrl_addr: rdata <= xi_ctrl[0];
        ric_pkg::ext_irq_2_ctrl_addr: rdata <= xi_ctrl[1];
        ric_pkg::ext_irq_3_ctrl_addr: rdata <= xi_ctrl[2];
        ric_pkg::system_config_2_addr: rdata <= sc2;
        default: rdata <= 8'h00;
      endcase
    end
  end

  // Externals take positions 0 to 2; peripheral lines fill the rest
  logic [num_irq-1:0] req;
  logic [num_irq-1:0] lvl1;
  logic nmi_req;
  logic arb_take;
  logic [3:0] arb_index;
  always_comb begin
    req = periph_irq;
    lvl1 = periph_level1;
    for (int i = 0; i < 3; i++) begin
      req[i] = xi_ctrl[i][ric_pkg::xi_flag_bit] & xi_ctrl[i][ric_pkg::xi_enable_bit];
      lvl1[i] = ~xi_ctrl[i][ric_pkg::xi_priority_bit];
    end
  end
  assign nmi_req = sc2[ric_pkg::nmi_select_bit] & xi_ctrl[0][ric_pkg::xi_flag_bit];
  ric_irq_arb #(.n(num_irq)) u_arb (
    .req(req),
    .level1_sel(lvl1),
    .level1_global_mask(cpu_status_reg[ric_pkg::status_l1_mask_bit]),
    .level2_global_mask(cpu_status_reg[ric_pkg::status_l2_mask_bit]),
    .nmi_req(nmi_req),
    .take(arb_take),
    .index(arb_index)
  );
  assign irq_take = arb_take & insn_done & ~cpu_reset;
  assign irq_index = arb_index;

  a_pin_low_eight: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(internal_src) |=> reset_pin_oe [*8]) else $error("reset pin drive too short");
  a_start_twenty: assert property (@(posedge sys_clk) disable iff (!rst_n)
    opcode_fetch |-> $past(state, 20) == ric_hold && $past(state, 19) == ric_wait)
    else $error("start sequence length wrong");
  a_vector_order: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state == ric_vlo && !any_src && !reset_pin_oe |=> state == ric_vhi) else $error("vector order wrong");
  a_status_init: assert property (@(posedge sys_clk) disable iff (!rst_n)
    opcode_fetch |-> cpu_init.stack_pointer == ric_pkg::stack_reset) else $error("stack pointer not one");
  a_hold_reset: assert property (@(posedge sys_clk) disable iff (!rst_n)
    osc_fault |=> cpu_reset) else $error("reset released during fault");
  a_flag_sticky: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wd_timeout |=> flag_wd) else $error("watchdog flag not set");
  a_irq_gated: assert property (@(posedge sys_clk) disable iff (!rst_n)
    irq_take |-> insn_done) else $error("interrupt taken mid instruction");
  a_nmi_wins: assert property (@(posedge sys_clk) disable iff (!rst_n)
    nmi_req && insn_done && !cpu_reset |-> irq_take && irq_index == 4'h0) else $error("nmi blocked");
  a_ext_drive: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ext_low |=> reset_pin_oe) else $error("external reset not driven");
  a_clear_ab: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clear_reg_ab |-> cpu_reset) else $error("register clear outside reset");
  a_xi_soft_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cpu_reset |=> xi_ctrl[1] == ric_pkg::xi_ctrl_reset) else $error("control not reset");
  a_mask_level1: assert property (@(posedge sys_clk) disable iff (!rst_n)
    irq_take && !nmi_req && !cpu_status_reg[ric_pkg::status_l1_mask_bit] |-> !lvl1[irq_index])
    else $error("masked level taken");
  a_nmi_lock: assert property (@(posedge sys_clk) disable iff (!rst_n)
    soft_rst_n && sc2[ric_pkg::privilege_disable_bit]
    |=> sc2[ric_pkg::nmi_select_bit] == $past(sc2[ric_pkg::nmi_select_bit]))
    else $error("nmi select changed while locked");
  c_fetch: cover property (@(posedge sys_clk) disable iff (!rst_n) opcode_fetch);
  c_irq: cover property (@(posedge sys_clk) disable iff (!rst_n) irq_take && irq_index != 4'h0);
  c_nmi: cover property (@(posedge sys_clk) disable iff (!rst_n) nmi_req && irq_take);
  c_ext_hold: cover property (@(posedge sys_clk) disable iff (!rst_n) ext_low);
  c_lock: cover property (@(posedge sys_clk) disable iff (!rst_n) nmi_req && sc2[ric_pkg::privilege_disable_bit]);
endmodule

/* File: core/ric_pkg.sv */
package ric_pkg;
  localparam logic [15:0] system_config_0_addr = 16'h1010;
  localparam logic [15:0] timer1_control_2_addr = 16'h104A;
  localparam logic [15:0] ext_irq_1_ctrl_addr = 16'h1017;
  localparam logic [15:0] ext_irq_2_ctrl_addr = 16'h1018;
  localparam logic [15:0] ext_irq_3_ctrl_addr = 16'h1019;
  localparam logic [15:0] system_config_2_addr = 16'h1012;
  localparam logic [15:0] vector_low_addr = 16'h7FFF;
  localparam logic [15:0] vector_high_addr = 16'h7FFE;
  localparam int power_up_bit = 7;
  localparam int osc_fault_bit = 4;
  localparam int wd_timeout_bit = 5;
  localparam int xi_enable_bit = 0;
  localparam int xi_polarity_bit = 1;
  localparam int xi_priority_bit = 4;
  localparam int xi_flag_bit = 7;
  localparam int privilege_disable_bit = 0;
  localparam int nmi_select_bit = 1;
  localparam logic [7:0] status_reset = 8'h00;
  localparam logic [7:0] stack_reset = 8'h01;
  localparam logic [7:0] reg_ab_reset = 8'h00;
  localparam logic [7:0] xi_ctrl_reset = 8'h00;
  localparam logic [7:0] sc2_reset = 8'h00;
  localparam int status_l1_mask_bit = 2;
  localparam int status_l2_mask_bit = 3;
  localparam int pin_low_cycles = 8;
  localparam int start_cycles = 20;
  localparam int num_sys_irq = 9;
  typedef struct packed {
    logic [15:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } ric_bus_type;
  typedef struct packed {
    logic [7:0] cpu_status_reg;
    logic [7:0] stack_pointer;
    logic [7:0] pc_low_byte;
    logic [7:0] pc_high_byte;
  } ric_cpu_init_type;
endpackage

/* File: core/ric_sync.sv */
`timescale 1ns/1ps
module ric_sync #(
  parameter int width = 4
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [width-1:0] din,
  output logic [width-1:0] dout
);
  logic [width-1:0] stage1;
  // Reset value high keeps the active-low pin idle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= '1;
      dout <= '1;
    end else begin
      stage1 <= din;
      dout <= stage1;
    end
  end
endmodule

/* File: core/ric_irq_arb.sv */
`timescale 1ns/1ps
module ric_irq_arb #(
  parameter int n = 9
) (
  input wire logic [n-1:0] req,
  input wire logic [n-1:0] level1_sel,
  input wire logic level1_global_mask,
  input wire logic level2_global_mask,
  input wire logic nmi_req,
  output logic take,
  output logic [3:0] index
);
  // Lowest position wins within a chain; level 1 beats level 2
  function automatic logic [4:0] first_set(input logic [n-1:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int i = n - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction
  logic [4:0] hit1;
  logic [4:0] hit2;
  always_comb begin
    hit1 = first_set(req & level1_sel & {n{level1_global_mask}});
    hit2 = first_set(req & ~level1_sel & {n{level2_global_mask}});
    take = 1'b0;
    index = 4'h0;
    if (nmi_req) begin
      take = 1'b1;
      index = 4'h0;
    end else if (hit1[4]) begin
      take = 1'b1;
      index = hit1[3:0];
    end else if (hit2[4]) begin
      take = 1'b1;
      index = hit2[3:0];
    end
  end
endmodule

/* File: sim/ric_board_model.sv */
`timescale 1ns/1ps
module ric_board_model #(
  parameter logic [7:0] vec_lo = 8'h34,
  parameter logic [7:0] vec_hi = 8'h12
) (
  input wire logic sys_clk,
  input wire logic board_low,
  input wire logic hold_insn,
  input wire logic reset_pin_out,
  input wire logic reset_pin_oe,
  input wire logic vec_read,
  input wire logic [15:0] vec_addr,
  output logic reset_pin_in,
  output logic [7:0] vec_data,
  output logic insn_done
);
  logic [7:0] last = 8'h5A;
  // Pulled up: low only while the device or the board pulls it
  assign reset_pin_in = !((reset_pin_oe && !reset_pin_out) || board_low);
  // Unselected memory shows a changing value, never a stale byte
  always_comb begin
    if (vec_read && vec_addr == ric_pkg::vector_low_addr) begin
      vec_data = vec_lo;
    end else if (vec_read && vec_addr == ric_pkg::vector_high_addr) begin
      vec_data = vec_hi;
    end else begin
      vec_data = ~last;
    end
  end
  always @(posedge sys_clk) begin
    last <= vec_data;
  end
  assign insn_done = !hold_insn;
endmodule

/* File: sim/tb_reset_and_interrupt_control.sv */
`timescale 1ns/1ps
module tb_reset_and_interrupt_control;
  logic sys_clk = 1'b0, nrst = 1'b0, board_low = 1'b0, hold_insn = 1'b0, mode_control_pin = 1'b0;
  logic [3:0] src = 4'h0;
  logic [2:0] ext_irq_in = 3'h0;
  logic [8:0] periph_irq = 9'h000, periph_level1 = 9'h000;
  logic [7:0] cpu_status_reg = 8'h00, rdata, vec_data;
  ric_pkg::ric_bus_type bus = '0;
  ric_pkg::ric_cpu_init_type cpu_init;
  logic reset_pin_in, reset_pin_out, reset_pin_oe, insn_done, mode_latched, cpu_reset;
  logic clear_reg_ab, vec_read, opcode_fetch, irq_take, got_fetch = 1'b0;
  logic [15:0] vec_addr;
  logic [3:0] irq_index;
  logic [15:0] vq[$];
  int mismatches = 0, n_tests = 0, since_hold = 0, oe_run = 0, last_run = 0, gap = 0;
  always #50 sys_clk = ~sys_clk;
  ric_top dut (.sys_clk(sys_clk), .nrst(nrst), .reset_pin_in(reset_pin_in), .reset_pin_out(reset_pin_out),
    .reset_pin_oe(reset_pin_oe), .power_up(src[3]), .osc_fault(src[2]), .wd_bad_key(src[1]),
    .wd_timeout(src[0]), .mode_control_pin(mode_control_pin), .ext_irq_in(ext_irq_in),
    .periph_irq(periph_irq), .periph_level1(periph_level1), .cpu_status_reg(cpu_status_reg),
    .insn_done(insn_done), .bus(bus), .rdata(rdata), .mode_latched(mode_latched), .cpu_reset(cpu_reset),
    .clear_reg_ab(clear_reg_ab), .cpu_init(cpu_init), .vec_read(vec_read), .vec_addr(vec_addr),
    .vec_data(vec_data), .opcode_fetch(opcode_fetch), .irq_take(irq_take), .irq_index(irq_index));
  ric_board_model board (.sys_clk(sys_clk), .board_low(board_low), .hold_insn(hold_insn),
    .reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe), .vec_read(vec_read), .vec_addr(vec_addr),
    .reset_pin_in(reset_pin_in), .vec_data(vec_data), .insn_done(insn_done));
  // Cycle counts measured at the pins
  always @(posedge sys_clk) begin
    since_hold <= clear_reg_ab ? 0 : since_hold + 1;
    oe_run <= reset_pin_oe ? oe_run + 1 : 0;
    if (!reset_pin_oe && oe_run > 0) begin
      last_run <= oe_run;
    end
    if (vec_read) begin
      vq.push_back(vec_addr);
    end
    if (opcode_fetch) begin
      got_fetch <= 1'b1;
      gap <= since_hold + 1;
    end
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus <= '{a, 1'b1, 1'b0, d};
    @(posedge sys_clk);
    bus <= '0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge sys_clk);
    bus <= '{a, 1'b0, 1'b1, 8'h00};
    @(posedge sys_clk);
    bus <= '0;
    #1;
    chk({8'h00, rdata & m}, {8'h00, e});
  endtask
  task automatic irq(input logic [8:0] rq, input logic [8:0] l1, input logic [7:0] st, input logic hd,
                     input logic [4:0] e);
    @(posedge sys_clk);
    periph_irq <= rq;
    periph_level1 <= l1;
    cpu_status_reg <= st;
    hold_insn <= hd;
    #1;
    chk({11'h000, irq_take, irq_take ? irq_index : 4'h0}, {11'h000, e});
  endtask
  task automatic wait_fetch(input logic m);
    int k;
    k = 0;
    while (!got_fetch && k < 300) begin
      @(posedge sys_clk);
      k++;
    end
    #1;
    chk({15'h0000, got_fetch}, 16'h0001);
    chk(16'(gap), 16'h0014);
    chk(vq[0], ric_pkg::vector_low_addr);
    chk(vq[1], ric_pkg::vector_high_addr);
    chk({cpu_init.pc_high_byte, cpu_init.pc_low_byte}, 16'h1234);
    chk({cpu_init.cpu_status_reg, cpu_init.stack_pointer}, 16'h0001);
    chk({15'h0000, last_run >= 8}, 16'h0001);
    chk({15'h0000, mode_latched}, {15'h0000, m});
    got_fetch = 1'b0;
    last_run = 0;
    vq.delete();
  endtask
  initial begin
    cyc(2);
    nrst <= 1'b1;
    wait_fetch(1'b0);
    // Flags power up unknown, so clear them before judging any source
    wr(ric_pkg::system_config_0_addr, 8'h00);
    wr(ric_pkg::timer1_control_2_addr, 8'h00);
    for (int i = 0; i < 5; i++) begin
      mode_control_pin <= i[0];
      cyc(1);
      src <= 4'h8 >> i;
      board_low <= (i == 4);
      cyc(30);
      chk({15'h0000, cpu_reset}, 16'h0001);
      chk({15'h0000, got_fetch}, 16'h0000);
      src <= 4'h0;
      board_low <= 1'b0;
      wait_fetch(i[0]);
      rd(ric_pkg::system_config_0_addr, 8'h90, {i == 0, 2'b00, i == 1, 4'h0});
      rd(ric_pkg::timer1_control_2_addr, 8'h20, {2'b00, i == 2 || i == 3, 5'h00});
      wr(ric_pkg::system_config_0_addr, 8'h00);
      wr(ric_pkg::timer1_control_2_addr, 8'h00);
    end
    rd(ric_pkg::ext_irq_3_ctrl_addr, 8'hFF, ric_pkg::xi_ctrl_reset);
    irq(9'h048, 9'h040, 8'h0C, 1'b0, 5'h16);
    irq(9'h048, 9'h040, 8'h08, 1'b0, 5'h13);
    irq(9'h048, 9'h040, 8'h04, 1'b0, 5'h16);
    irq(9'h008, 9'h000, 8'h04, 1'b0, 5'h00);
    irq(9'h090, 9'h000, 8'h0C, 1'b0, 5'h14);
    irq(9'h090, 9'h080, 8'h0C, 1'b0, 5'h17);
    irq(9'h100, 9'h000, 8'h0C, 1'b0, 5'h18);
    irq(9'h048, 9'h040, 8'h0C, 1'b1, 5'h00);
    wr(ric_pkg::ext_irq_1_ctrl_addr, 8'h03);
    wr(ric_pkg::ext_irq_2_ctrl_addr, 8'h01);
    ext_irq_in <= 3'h3;
    cyc(5);
    rd(ric_pkg::ext_irq_1_ctrl_addr, 8'h80, 8'h80);
    rd(ric_pkg::ext_irq_2_ctrl_addr, 8'h80, 8'h00);
    irq(9'h000, 9'h000, 8'h0C, 1'b0, 5'h10);
    ext_irq_in <= 3'h0;
    cyc(5);
    rd(ric_pkg::ext_irq_2_ctrl_addr, 8'h80, 8'h80);
    irq(9'h000, 9'h000, 8'h00, 1'b0, 5'h00);
    wr(ric_pkg::system_config_2_addr, 8'h02);
    irq(9'h000, 9'h000, 8'h00, 1'b0, 5'h10);
    // Once locked, an attempt to drop the select must not land
    wr(ric_pkg::system_config_2_addr, 8'h03);
    wr(ric_pkg::system_config_2_addr, 8'h01);
    rd(ric_pkg::system_config_2_addr, 8'h02, 8'h02);
    rd(16'h1080, 8'hFF, 8'h00);
    report_and_stop();
  end
  initial begin
    #300000;
    mismatches++;
    report_and_stop();
  end
endmodule
